// file: hdl/ssb_defines.vh
// Constants for the shadow-set binding register bank.
// Assumes inclusion by bare name from the design files of this block.
// Operation
// - Upper maps at register 6 select 4/5
// - Bit 31 read-only: next map present
// - Sets 12/11/10 in 29:20/19:10/9:0
// - Sets 15/14/13 in 29:20/19:10/9:0
// - Reserved bits read zero; software writes zero
// - Tied-off slot reads all ones
// - Unsupported slots contiguous from the top
// - Next flag only if all lower slots (10/11/12) instantiated
// - Highest set tracks valid slots at run time
// - Zero set means own thread file
// - Thread exceptions use code 25
// - Duplicate TLB entries suppressed silently
// - Step and parked flags per thread
// - Distinct processor number per virtual processor
// - Config fields writable in configuration state
// - Threading-present flag at config three bit 2
// - Decode halted, free, running, blocked
// - Programmable slots reset to 0x3FE
// - 0x3FF or 0x3FE marks slot invalid
// - Ignore assignment of unbound thread context
// - Highest set is lowest invalid minus one
`ifndef SSB_DEFINES_VH
`define SSB_DEFINES_VH
`define SSB_REG_NUM 5'h06
`define SSB_SEL_THREE 3'h4
`define SSB_SEL_FOUR 3'h5
`define SSB_NEXT_BIT 31
`define SSB_SLOT_W 10
`define SSB_SLOT_HI_LSB 20
`define SSB_SLOT_MID_LSB 10
`define SSB_SLOT_LO_LSB 0
`define SSB_SLOT_RESET 10'h3FE
`define SSB_SLOT_TIED 10'h3FF
`define SSB_EXC_THREAD 5'h19
`define SSB_CFG3_MT_BIT 2
`define SSB_ST_HALTED 4'h1
`define SSB_ST_FREE 4'h2
`define SSB_ST_RUNNING 4'h4
`define SSB_ST_BLOCKED 4'h8
`endif

// file: hdl/ssb_slot.v
// One shadow slot field: programmable, read-only preset or tied off.
// Assumes the owner decodes the write strobe and binding check.
`include "ssb_defines.vh"
module ssb_slot #(
   parameter MODE = 0,
   parameter [9:0] PRESET = 10'h3FE
) (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Write side
   input wire wr_en,
   input wire wr_bound,
   input wire [9:0] wr_data,
   // Field value
   output wire [9:0] value
);
   // MODE 0 programmable, 1 read-only preset, 2 tied off
   reg [9:0] slot;
   always @(posedge clk) begin
      if (sys_rst)
         slot <= `SSB_SLOT_RESET;
      else if (MODE == 0 && wr_en && wr_bound)
         slot <= wr_data;
   end
   assign value = (MODE == 2) ? `SSB_SLOT_TIED :
                  (MODE == 1) ? PRESET : slot;
endmodule

// file: hdl/ssb_bank.v
// Shadow-set binding registers for one virtual processor, plus related
// privileged-state helpers. Assumes a same-clock system-control move port.
`include "ssb_defines.vh"
module ssb_bank #(
   parameter NTC = 8,
   parameter MODE10 = 0,
   parameter MODE11 = 0,
   parameter MODE12 = 0,
   parameter MODE13 = 0,
   parameter MODE14 = 0,
   parameter MODE15 = 2,
   parameter [9:0] PRESET10 = 10'h3FE,
   parameter [9:0] PRESET11 = 10'h3FE,
   parameter [9:0] PRESET12 = 10'h3FE,
   parameter [9:0] PRESET13 = 10'h3FE,
   parameter [9:0] PRESET14 = 10'h3FE,
   parameter [9:0] PRESET15 = 10'h3FE,
   parameter [3:0] LOW_HSS = 4'h9,
   parameter [3:0] VPE_NUM = 4'h0,
   parameter [9:0] CPU_NUM = 10'h000,
   parameter [7:0] CFG1_INIT = 8'h00
) (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // System-control move port
   input wire mv_wr,
   input wire mv_rd,
   input wire [4:0] mv_reg,
   input wire [2:0] mv_sel,
   input wire [31:0] mv_wdata,
   output reg [31:0] mv_rdata,
   output reg mv_hit,
   // Thread binding lookup
   input wire [NTC*4-1:0] tc_bound_vpe,
   // Shadow set control
   input wire [3:0] current_shadow_set,
   input wire [3:0] previous_shadow_set,
   input wire [7:0] serving_thread_number,
   output reg [3:0] highest_shadow_set,
   output wire css_own_file,
   output wire pss_own_file,
   output wire [7:0] css_file_thread,
   // Thread exception
   input wire thread_exc,
   output reg [4:0] exception_code_field,
   output reg exc_code_valid,
   // TLB duplicate handling
   input wire tlb_dup_hit,
   input wire tlb_write,
   output wire tlb_write_commit,
   output wire machine_check,
   // Debug per thread
   input wire [7:0] dbg_tc,
   input wire dbg_wr,
   input wire single_step_in,
   input wire parked_in,
   output wire single_step_flag,
   output wire thread_parked_flag,
   // Processor number and configuration
   output wire [9:0] processor_number,
   input wire config_state_bit,
   input wire cfg1_wr,
   input wire [7:0] cfg1_wdata,
   output reg [5:0] tlb_size_field,
   output reg cop_two_present,
   output reg media_ext_present,
   output reg float_unit_present,
   output wire threading_present,
   output wire [31:0] config_word_three,
   // Thread state decode
   input wire stop_bit,
   input wire live_bit,
   input wire [2:0] run_state_code,
   output reg [3:0] thread_state
);
   // Slot build mode for a slot that is not there
   localparam M_TIED = 2;
   // Upper map exists only when every lower slot is built; kept constant
   // because it also decides how the upper slots are built
   localparam [0:0] NEXT_FLAG = (MODE10 != M_TIED) && (MODE11 != M_TIED) && (MODE12 != M_TIED);
   localparam EMODE13 = NEXT_FLAG ? MODE13 : M_TIED;
   localparam EMODE14 = NEXT_FLAG ? MODE14 : M_TIED;
   localparam EMODE15 = NEXT_FLAG ? MODE15 : M_TIED;

   // Register and select decode shared by both maps
   function map_sel;
      input [4:0] r;
      input [2:0] s;
      input [2:0] want;
      begin
         map_sel = (r == `SSB_REG_NUM) && (s == want);
      end
   endfunction

   // Word layout shared by both maps; bit 30 always reads zero
   function [31:0] map_word;
      input top;
      input [9:0] hi;
      input [9:0] mid;
      input [9:0] lo;
      begin
         map_word = {top, 1'b0, hi, mid, lo};
      end
   endfunction

   wire [9:0] s10, s11, s12, s13, s14, s15;
   wire sel3 = map_sel(mv_reg, mv_sel, `SSB_SEL_THREE);
   wire sel4 = map_sel(mv_reg, mv_sel, `SSB_SEL_FOUR);
   wire next_flag = NEXT_FLAG;

   function invalid_slot;
      input [9:0] v;
      begin
         invalid_slot = (v == `SSB_SLOT_TIED) || (v == `SSB_SLOT_RESET);
      end
   endfunction

   // Bound if the named context belongs to this virtual processor, or if the value marks the slot invalid
   function bound_ok;
      input [9:0] v;
      input [NTC*4-1:0] map;
      integer i;
      begin
         bound_ok = 1'b0;
         for (i = 0; i < NTC; i = i + 1)
            if (v == i[9:0] && map[i*4 +: 4] == VPE_NUM)
               bound_ok = 1'b1;
         if (invalid_slot(v))
            bound_ok = 1'b1; // Reclaiming a slot needs no binding
      end
   endfunction

   wire w3 = mv_wr && sel3;
   wire w4 = mv_wr && sel4;
   wire [9:0] d_hi = mv_wdata[`SSB_SLOT_HI_LSB +: 10];
   wire [9:0] d_mid = mv_wdata[`SSB_SLOT_MID_LSB +: 10];
   wire [9:0] d_lo = mv_wdata[`SSB_SLOT_LO_LSB +: 10];
   wire b_hi = bound_ok(d_hi, tc_bound_vpe);
   wire b_mid = bound_ok(d_mid, tc_bound_vpe);
   wire b_lo = bound_ok(d_lo, tc_bound_vpe);

   ssb_slot #(.MODE(MODE10), .PRESET(PRESET10)) u_s10 (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(w3),
      .wr_bound(b_lo),
      .wr_data(d_lo),
      .value(s10)
   );
   ssb_slot #(.MODE(MODE11), .PRESET(PRESET11)) u_s11 (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(w3),
      .wr_bound(b_mid),
      .wr_data(d_mid),
      .value(s11)
   );
   ssb_slot #(.MODE(MODE12), .PRESET(PRESET12)) u_s12 (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(w3),
      .wr_bound(b_hi),
      .wr_data(d_hi),
      .value(s12)
   );
   ssb_slot #(.MODE(EMODE13), .PRESET(PRESET13)) u_s13 (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(w4),
      .wr_bound(b_lo),
      .wr_data(d_lo),
      .value(s13)
   );
   ssb_slot #(.MODE(EMODE14), .PRESET(PRESET14)) u_s14 (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(w4),
      .wr_bound(b_mid),
      .wr_data(d_mid),
      .value(s14)
   );
   ssb_slot #(.MODE(EMODE15), .PRESET(PRESET15)) u_s15 (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(w4),
      .wr_bound(b_hi),
      .wr_data(d_hi),
      .value(s15)
   );

   // Read mux; anything but a present map reads zero
   reg [31:0] next_rdata;
   reg next_hit;
   always @* begin
      next_rdata = 32'h00000000;
      next_hit = 1'b0;
      if (mv_rd && sel3) begin
         next_rdata = map_word(next_flag, s12, s11, s10);
         next_hit = 1'b1;
      end else if (mv_rd && sel4 && next_flag) begin
         next_rdata = map_word(1'b0, s15, s14, s13);
         next_hit = 1'b1;
      end
   end
   always @(posedge clk) begin
      if (sys_rst) begin
         mv_rdata <= 32'h00000000;
         mv_hit <= 1'b0;
      end else begin
         mv_rdata <= next_rdata;
         mv_hit <= next_hit;
      end
   end

   // Highest valid set: stop at the first invalid slot from the bottom.
   // Contiguity of supported slots keeps this a simple scan.
   reg [3:0] next_hss;
   always @* begin
      next_hss = 4'hF;
      if (invalid_slot(s15)) next_hss = 4'hE;
      if (invalid_slot(s14)) next_hss = 4'hD;
      if (invalid_slot(s13)) next_hss = 4'hC;
      if (invalid_slot(s12)) next_hss = 4'hB;
      if (invalid_slot(s11)) next_hss = 4'hA;
      if (invalid_slot(s10)) next_hss = LOW_HSS;
   end
   always @(posedge clk) begin
      if (sys_rst)
         highest_shadow_set <= 4'h0;
      else
         highest_shadow_set <= next_hss;
   end

   // Set zero selects the servicing thread's own file
   assign css_own_file = (current_shadow_set == 4'h0);
   assign pss_own_file = (previous_shadow_set == 4'h0);
   assign css_file_thread = css_own_file ? serving_thread_number : 8'h00;

   always @(posedge clk) begin
      if (sys_rst) begin
         exception_code_field <= 5'h00;
         exc_code_valid <= 1'b0;
      end else begin
         exc_code_valid <= thread_exc;
         if (thread_exc)
            exception_code_field <= `SSB_EXC_THREAD;
      end
   end

   // Duplicate entries dropped without a machine check
   assign tlb_write_commit = tlb_write && !tlb_dup_hit;
   assign machine_check = 1'b0;

   // Per-thread debug flags; other debug fields stay per virtual processor
   reg [NTC-1:0] step_q;
   reg [NTC-1:0] park_q;
   reg [NTC-1:0] next_step;
   reg [NTC-1:0] next_park;
   integer k;
   always @* begin
      next_step = step_q;
      next_park = park_q;
      for (k = 0; k < NTC; k = k + 1)
         if (dbg_wr && dbg_tc == k[7:0]) begin
            next_step[k] = single_step_in;
            next_park[k] = parked_in;
         end
   end
   always @(posedge clk) begin
      if (sys_rst) begin
         step_q <= {NTC{1'b0}};
         park_q <= {NTC{1'b0}};
      end else begin
         step_q <= next_step;
         park_q <= next_park;
      end
   end
   assign single_step_flag = step_q[dbg_tc[2:0]];
   assign thread_parked_flag = park_q[dbg_tc[2:0]];

   assign processor_number = CPU_NUM;

   // Presence fields writable only in configuration state
   reg [5:0] next_tlb_size;
   reg next_cop_two;
   reg next_media;
   reg next_float;
   always @* begin
      next_tlb_size = tlb_size_field;
      next_cop_two = cop_two_present;
      next_media = media_ext_present;
      next_float = float_unit_present;
      if (cfg1_wr && config_state_bit) begin
         next_tlb_size = cfg1_wdata[7:2];
         next_cop_two = cfg1_wdata[1];
         next_media = cfg1_wdata[0];
         next_float = cfg1_wdata[0] | cfg1_wdata[1];
      end
   end
   always @(posedge clk) begin
      if (sys_rst) begin
         tlb_size_field <= CFG1_INIT[7:2];
         cop_two_present <= CFG1_INIT[1];
         media_ext_present <= CFG1_INIT[0];
         float_unit_present <= 1'b0;
      end else begin
         tlb_size_field <= next_tlb_size;
         cop_two_present <= next_cop_two;
         media_ext_present <= next_media;
         float_unit_present <= next_float;
      end
   end

   assign threading_present = 1'b1;
   assign config_word_three = {29'h0000000, threading_present, 2'b00};

   // Thread state from halt, live and run-state inputs; halt wins over all
   function [3:0] decode_state;
      input halt;
      input live;
      input [2:0] run;
      begin
         if (halt)
            decode_state = `SSB_ST_HALTED;
         else if (!live)
            decode_state = `SSB_ST_FREE;
         else if (run == 3'h0)
            decode_state = `SSB_ST_RUNNING;
         else
            decode_state = `SSB_ST_BLOCKED;
      end
   endfunction

   always @(posedge clk) begin
      if (sys_rst)
         thread_state <= `SSB_ST_FREE;
      else
         thread_state <= decode_state(stop_bit, live_bit, run_state_code);
   end
endmodule

// file: test/ssb_bank_asserts.sv
// Port assertions for the shadow-set binding bank.
// Assumes default slot modes, so the second map register exists.
module ssb_bank_asserts (
   // Clock, reset and move port
   input wire clk,
   input wire sys_rst,
   input wire mv_rd,
   input wire [4:0] mv_reg,
   input wire [2:0] mv_sel,
   input wire [31:0] mv_rdata,
   input wire mv_hit,
   // Status side
   input wire thread_exc,
   input wire [4:0] exception_code_field,
   input wire tlb_dup_hit,
   input wire tlb_write,
   input wire tlb_write_commit,
   input wire machine_check,
   input wire threading_present,
   input wire [31:0] config_word_three,
   input wire stop_bit,
   input wire live_bit,
   input wire [2:0] run_state_code,
   input wire [3:0] thread_state
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   map_hit_a: assert property (mv_rd && mv_reg == 5'h06 && mv_sel == 3'h4 |=> mv_hit)
      else $error("map read not answered");
   stray_miss_a: assert property (mv_rd && mv_reg != 5'h06 |=> !mv_hit && mv_rdata == 32'h0)
      else $error("stray read answered");
   resv_zero_a: assert property (mv_hit |-> !mv_rdata[30])
      else $error("bit 30 set");
   top_resv_a: assert property (mv_hit && $past(mv_sel) == 3'h5 |-> mv_rdata[31:30] == 2'b00)
      else $error("upper map top bits set");
   thread_code_a: assert property (thread_exc |=> exception_code_field == 5'h19)
      else $error("thread code wrong");
   tlb_quiet_a: assert property (tlb_write_commit == (tlb_write && !tlb_dup_hit) && !machine_check)
      else $error("duplicate handling wrong");
   mt_flag_a: assert property (threading_present && config_word_three[2])
      else $error("threading flag clear");
   state_dec_a: assert property (1'b1 |=> thread_state == ($past(stop_bit) ? 4'h1 :
      !$past(live_bit) ? 4'h2 : $past(run_state_code) == 3'h0 ? 4'h4 : 4'h8))
      else $error("thread state decode wrong");
endmodule
bind ssb_bank ssb_bank_asserts ssb_bank_asserts_i (.clk, .sys_rst, .mv_rd, .mv_reg, .mv_sel, .mv_rdata, .mv_hit,
   .thread_exc, .exception_code_field, .tlb_dup_hit, .tlb_write, .tlb_write_commit, .machine_check,
   .threading_present, .config_word_three, .stop_bit, .live_bit, .run_state_code, .thread_state);

// file: test/ssb_bank_tb_top.sv
// Self-checking bench for the shadow-set binding bank at default parameters.
// Assumes slot 15 tied off and the bank owned by virtual processor 0.
module ssb_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, mv_wr, mv_rd, mv_hit, thread_exc, exc_code_valid, tlb_dup_hit, tlb_write;
   logic tlb_write_commit, machine_check, dbg_wr, single_step_in, parked_in, single_step_flag;
   logic thread_parked_flag, config_state_bit, cfg1_wr, cop_two_present, media_ext_present;
   logic float_unit_present, threading_present, stop_bit, live_bit, css_own_file, pss_own_file;
   logic [4:0] mv_reg, exception_code_field;
   logic [2:0] mv_sel, run_state_code;
   logic [31:0] mv_wdata, mv_rdata, tc_bound_vpe, config_word_three;
   logic [3:0] current_shadow_set, previous_shadow_set, highest_shadow_set, thread_state;
   logic [7:0] serving_thread_number, css_file_thread, dbg_tc, cfg1_wdata;
   logic [9:0] processor_number;
   logic [5:0] tlb_size_field;
   logic [9:0] slot [10:15];
   logic [7:0] st = 8'h00, pk = 8'h00, cfg = 8'h00;
   logic exc_seen = 1'b0;
   int n_mismatch = 0;
   int comparisons = 0;
   ssb_bank ssb_bank_i (.clk, .sys_rst, .mv_wr, .mv_rd, .mv_reg, .mv_sel, .mv_wdata, .mv_rdata, .mv_hit,
      .tc_bound_vpe, .current_shadow_set, .previous_shadow_set, .serving_thread_number, .highest_shadow_set,
      .css_own_file, .pss_own_file, .css_file_thread, .thread_exc, .exception_code_field, .exc_code_valid,
      .tlb_dup_hit, .tlb_write, .tlb_write_commit, .machine_check, .dbg_tc, .dbg_wr, .single_step_in,
      .parked_in, .single_step_flag, .thread_parked_flag, .processor_number, .config_state_bit, .cfg1_wr,
      .cfg1_wdata, .tlb_size_field, .cop_two_present, .media_ext_present, .float_unit_present,
      .threading_present, .config_word_three, .stop_bit, .live_bit, .run_state_code, .thread_state);
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (exp !== got) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Request held one cycle; read data is settled after the final edge
   task automatic mv(logic wr, logic [4:0] r, logic [2:0] sel, logic [31:0] d);
      @(posedge clk);
      mv_wr <= wr;
      mv_rd <= !wr;
      mv_reg <= r;
      mv_sel <= sel;
      mv_wdata <= d;
      @(posedge clk);
      mv_wr <= 1'b0;
      mv_rd <= 1'b0;
      #1;
   endtask
   function automatic logic [31:0] word(logic [2:0] sel);
      int b = (sel == 3'h4) ? 10 : 13;
      return {sel == 3'h4, 1'b0, slot[b + 2], slot[b + 1], slot[b]};
   endfunction
   function automatic logic [3:0] hss_exp();
      for (int i = 10; i < 16; i++)
         if (slot[i] >= 10'h3FE) return 4'(i - 1);
      return 4'hF;
   endfunction
   task automatic wr_map(logic [2:0] sel, logic [31:0] d);
      int b = (sel == 3'h4) ? 10 : 13;
      logic [9:0] v;
      mv(1'b1, 5'h06, sel, d);
      for (int i = 0; i < 3; i++) begin
         v = d[i * 10 +: 10];
         if (b + i < 15 && (v >= 10'h3FE || (v < 10'h008 && tc_bound_vpe[v[2:0] * 4 +: 4] == 4'h0)))
            slot[b + i] = v;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #40000;
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      logic [31:0] d;
      logic [2:0] sel;
      logic [9:0] v;
      {mv_wr, mv_rd, mv_reg, mv_sel, mv_wdata, tc_bound_vpe, thread_exc, tlb_dup_hit, tlb_write} = '0;
      {current_shadow_set, previous_shadow_set, serving_thread_number, dbg_tc, dbg_wr} = '0;
      {single_step_in, parked_in, config_state_bit, cfg1_wr, cfg1_wdata, stop_bit, live_bit} = '0;
      run_state_code = 3'h0;
      sys_rst = 1'b1;
      foreach (slot[i]) slot[i] = 10'h3FE;
      slot[15] = 10'h3FF;
      void'($urandom(32'h2f5eb4fb));
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      for (int s = 4; s < 6; s++) begin
         mv(1'b0, 5'h06, 3'(s), 32'h0);
         chk("map", word(3'(s)), mv_rdata);
         chk("hit", 1, mv_hit);
      end
      mv(1'b0, 5'h07, 3'h4, 32'h0);
      chk("stray hit", 0, mv_hit);
      chk("hss", hss_exp(), highest_shadow_set);
      $display("reset test done");
      for (int k = 0; k < 300; k++) begin
         @(posedge clk);
         tc_bound_vpe <= $urandom & 32'h11111111;
         {stop_bit, live_bit, run_state_code, tlb_write, tlb_dup_hit} <= 7'($urandom);
         {thread_exc, dbg_wr, single_step_in, parked_in, config_state_bit, cfg1_wr} <= 6'($urandom);
         current_shadow_set <= 4'($urandom % 10);
         previous_shadow_set <= 4'($urandom % 10);
         serving_thread_number <= 8'($urandom);
         dbg_tc <= 8'($urandom % 8);
         cfg1_wdata <= 8'($urandom);
         sel = ($urandom % 2) ? 3'h5 : 3'h4;
         for (int i = 0; i < 3; i++) begin
            v = 10'($urandom % 12);
            d[i * 10 +: 10] = (v > 9) ? v + 10'h3F4 : v;
         end
         d[31:30] = 2'b00;
         wr_map(sel, d);
         mv(1'b0, 5'h06, sel, 32'h0);
         chk("map", word(sel), mv_rdata);
         chk("hss", hss_exp(), highest_shadow_set);
         chk("own", current_shadow_set == 4'h0, css_own_file);
         if (dbg_wr) begin
            st[dbg_tc[2:0]] = single_step_in;
            pk[dbg_tc[2:0]] = parked_in;
         end
         chk("debug", {st[dbg_tc[2:0]], pk[dbg_tc[2:0]]}, {single_step_flag, thread_parked_flag});
         if (config_state_bit && cfg1_wr) cfg = cfg1_wdata;
         chk("config", cfg[7:1], {tlb_size_field, cop_two_present});
         chk("media float", {cfg[0], cfg[0] | cfg[1]}, {media_ext_present, float_unit_present});
         if (thread_exc) exc_seen = 1'b1;
         chk("exc code", exc_seen ? 5'h19 : 5'h00, exception_code_field);
         chk("exc valid", thread_exc, exc_code_valid);
         chk("commit", tlb_write && !tlb_dup_hit, tlb_write_commit);
         chk("mcheck", 0, machine_check);
         chk("pss own", previous_shadow_set == 4'h0, pss_own_file);
         chk("file thr", current_shadow_set == 4'h0 ? serving_thread_number : 8'h00, css_file_thread);
         chk("state", stop_bit ? 1 : !live_bit ? 2 : (run_state_code == 0) ? 4 : 8, thread_state);
         chk("config_word_three", 32'h00000004, config_word_three);
         chk("cpu", 0, processor_number);
      end
      $display("random test done");
      // Mid-run reset must restore every preset
      @(posedge clk);
      sys_rst <= 1'b1;
      {thread_exc, stop_bit, live_bit, run_state_code, cfg1_wr, dbg_wr} <= '0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (slot[i]) slot[i] = (i == 15) ? 10'h3FF : 10'h3FE;
      {st, pk, cfg, exc_seen} = '0;
      for (int s = 4; s < 6; s++) begin
         mv(1'b0, 5'h06, 3'(s), 32'h0);
         chk("map", word(3'(s)), mv_rdata);
      end
      chk("hss", hss_exp(), highest_shadow_set);
      chk("exc code", 5'h00, exception_code_field);
      chk("config", cfg, {tlb_size_field, cop_two_present, media_ext_present});
      chk("debug", 0, {single_step_flag, thread_parked_flag});
      $display("reset rerun test done");
      tally_and_finish;
   end
endmodule
